// *** hw/ee_cfg.svh ***
// Constants shared by both ends of the two-wire memory link
`ifndef EE_CFG_SVH
`define EE_CFG_SVH

// ----------------------------------------------------------------
// Addressing
// ----------------------------------------------------------------
`define EE_DEV_TYPE 4'hA
`define EE_ADDR_BITS 15
`define EE_PAGE_BITS 6
`define EE_ERASED 8'hFF
`define EE_BIT_LAST 4'h8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define EE_TWR_NS 5000000
`define EE_LINK_PERIOD_NS 15
`define EE_CORE_PERIOD_PS 8000
`define EE_SCL_PERIOD_PS 2500000

`endif

// *** hw/ee_pkg.sv ***
// Types shared by both ends of the two-wire memory link
package ee_pkg;

  typedef enum logic [2:0] {
    EE_IDLE  = 3'h0,
    EE_RX    = 3'h1,
    EE_ACK   = 3'h2,
    EE_TX    = 3'h3,
    EE_TXACK = 3'h4
  } ee_slave_state_type;

  typedef enum logic [1:0] {
    EE_DEVB = 2'h0,
    EE_ADRH = 2'h1,
    EE_ADRL = 2'h2,
    EE_DATA = 2'h3
  } ee_byte_kind_type;

  typedef enum logic [1:0] {
    EE_OP_START = 2'h0,
    EE_OP_STOP  = 2'h1,
    EE_OP_WRITE = 2'h2,
    EE_OP_READ  = 2'h3
  } ee_op_type;

  typedef enum logic [1:0] {
    EE_M_IDLE  = 2'h0,
    EE_M_START = 2'h1,
    EE_M_STOP  = 2'h2,
    EE_M_BIT   = 2'h3
  } ee_master_state_type;

endpackage : ee_pkg

// *** hw/ee_link_if.sv ***
// Two-wire bus between the master end and the memory end
`timescale 1ns/1ps
`default_nettype none

interface ee_link_if;
  logic sclOe;
  logic sclOut;
  logic sdaMasterOe;
  logic sdaMasterOut;
  logic sdaSlaveOe;
  logic sdaSlaveOut;
  logic scl;
  logic sda;

  // ----------------------------------------------------------------
  // Wired-AND with pull-up
  // ----------------------------------------------------------------
  assign scl = !(sclOe && !sclOut);
  assign sda = !(sdaMasterOe && !sdaMasterOut) && !(sdaSlaveOe && !sdaSlaveOut);

  modport master (
    output sclOe,
    output sclOut,
    output sdaMasterOe,
    output sdaMasterOut,
    input scl,
    input sda
  );

  modport slave (
    output sdaSlaveOe,
    output sdaSlaveOut,
    input scl,
    input sda
  );
endinterface : ee_link_if

`default_nettype wire

// *** hw/ee_eeprom_slave.sv ***
// Memory end: two-wire slave with page buffer, write cycle and array
// Function
// - Supply loss resets interface; restore gives standby
// - Sample on clock rise, drive after fall
// - Straps and protect input default low
// - Master makes clock, START, STOP when idle
// - Transmitter pulls low for zero, releases for one
// - Data change during clock high is condition
// - START is fall while high; ignore before
// - STOP ends write into programming, read idle
// - Address 1010, strap match, last bit read
// - Acknowledge address, address bytes, written data
// - Read bytes continue on ack, nack ends
// - Byte write: header, two addresses, data, STOP
// - Top bit ignored, 9 page, 6 byte
// - Up to 64 bytes, address advancing
// - Beyond 64 bytes wraps inside page
// - No address acknowledge while programming
// - Protect sampled before first data; rejects write
// - Array starts all bytes erased FFh
// - Counter points one past last access
// - Read header acknowledged, then counter byte sent
// - Random read: dummy write header, repeated START
// - Sequential reads wrap at memory end
`timescale 1ns/1ps
`default_nettype none
`include "ee_cfg.svh"

module ee_eeprom_slave #(
  parameter int ADDR_BITS = `EE_ADDR_BITS,
  parameter int PAGE_BITS = `EE_PAGE_BITS,
  parameter int WRITE_CYCLES = `EE_TWR_NS / `EE_LINK_PERIOD_NS
) (
  // Link clock and power-on level
  input wire logic linkClk,
  input wire logic rst_n,
  // Bus
  ee_link_if.slave bus,
  // Straps
  input wire logic device_select_strap0,
  input wire logic device_select_strap1,
  input wire logic device_select_strap2,
  input wire logic writeProtect,
  // Status
  output logic busy
);

  localparam int MEM_BYTES = 1 << ADDR_BITS;
  localparam int PAGE_BYTES = 1 << PAGE_BITS;
  localparam int PAGE_NUM_BITS = ADDR_BITS - PAGE_BITS;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0] sclSync;
  logic [1:0] sdaSync;
  logic [1:0] wpSync;
  logic [2:0] strapMeta;
  logic [2:0] strapSync;
  logic sclPrev;
  logic sdaPrev;
  logic sclS;
  logic sdaS;
  logic startCond;
  logic stopCond;
  logic sclRise;
  logic sclFall;
  ee_pkg::ee_slave_state_type state;
  ee_pkg::ee_byte_kind_type kind;
  logic [3:0] bitCnt;
  logic [7:0] shiftIn;
  logic [7:0] txShift;
  logic readMode;
  logic ackSeen;
  logic sdaOe;
  logic rxDone;
  logic ackNow;
  logic txLoad;
  logic [7:0] memByte;
  logic [ADDR_BITS-1:0] addrCnt;
  logic wpLatched;
  logic dataSeen;
  logic [PAGE_BYTES-1:0] pageValid;
  logic [7:0] pageBuf [PAGE_BYTES];
  // Declaration initialiser keeps the array single-driven by the write process
  logic [7:0] mem [MEM_BYTES] = '{default: `EE_ERASED};
  logic [1:0] rstSync;
  logic linkRst_n;
  logic [31:0] busyCnt;
  logic [PAGE_BITS:0] progIdx;
  logic [PAGE_NUM_BITS-1:0] progPage;
  logic sdaOutReg;

  function automatic logic devMatch(input logic [7:0] b, input logic [2:0] straps);
    devMatch = (b[7:4] == `EE_DEV_TYPE) && (b[3:1] == straps);
  endfunction : devMatch

  function automatic ee_pkg::ee_byte_kind_type nextKind(input ee_pkg::ee_byte_kind_type k);
    unique case (k)
      ee_pkg::EE_DEVB: nextKind = ee_pkg::EE_ADRH;
      ee_pkg::EE_ADRH: nextKind = ee_pkg::EE_ADRL;
      ee_pkg::EE_ADRL: nextKind = ee_pkg::EE_DATA;
      ee_pkg::EE_DATA: nextKind = ee_pkg::EE_DATA;
    endcase
  endfunction : nextKind

  // ----------------------------------------------------------------
  // Input synchronisers and edge detection
  // ----------------------------------------------------------------
  always_ff @(posedge linkClk) begin
    sclSync <= {sclSync[0], bus.scl};
    sdaSync <= {sdaSync[0], bus.sda};
    wpSync <= {wpSync[0], writeProtect};
    strapMeta <= {device_select_strap2, device_select_strap1, device_select_strap0};
    strapSync <= strapMeta;
    // Power-on level arrives from outside the link domain
    rstSync <= {rstSync[0], rst_n};
  end

  assign linkRst_n = rstSync[1];

  always_ff @(posedge linkClk) begin
    if (!linkRst_n) begin
      sclPrev <= 1'h1;
      sdaPrev <= 1'h1;
    end else begin
      sclPrev <= sclSync[1];
      sdaPrev <= sdaSync[1];
    end
  end

  assign sclS = sclSync[1];
  assign sdaS = sdaSync[1];
  // The data line falling or rising while the clock stays high is a condition
  assign startCond = sclS && sclPrev && sdaPrev && !sdaS;
  assign stopCond = sclS && sclPrev && !sdaPrev && sdaS;
  assign sclRise = sclS && !sclPrev;
  assign sclFall = !sclS && sclPrev;

  // ----------------------------------------------------------------
  // Byte decode
  // ----------------------------------------------------------------
  assign rxDone = (state == ee_pkg::EE_RX) && sclFall && (bitCnt == `EE_BIT_LAST);
  assign memByte = mem[addrCnt];
  assign txLoad = sclFall && readMode &&
                  ((state == ee_pkg::EE_ACK) || ((state == ee_pkg::EE_TXACK) && ackSeen));

  always_comb begin
    unique case (kind)
      ee_pkg::EE_DEVB: ackNow = devMatch(shiftIn, strapSync) && !busy;
      ee_pkg::EE_ADRH: ackNow = 1'h1;
      ee_pkg::EE_ADRL: ackNow = 1'h1;
      ee_pkg::EE_DATA: ackNow = !wpLatched;
    endcase
  end

  // ----------------------------------------------------------------
  // Bit sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge linkClk) begin
    if (!linkRst_n) begin
      state <= ee_pkg::EE_IDLE;
      kind <= ee_pkg::EE_DEVB;
      bitCnt <= 4'h0;
      shiftIn <= 8'h00;
      txShift <= 8'h00;
      readMode <= 1'h0;
      ackSeen <= 1'h0;
      sdaOe <= 1'h0;
    end else if (startCond) begin
      state <= ee_pkg::EE_RX;
      kind <= ee_pkg::EE_DEVB;
      bitCnt <= 4'h0;
      sdaOe <= 1'h0;
    end else if (stopCond) begin
      state <= ee_pkg::EE_IDLE;
      sdaOe <= 1'h0;
    end else begin
      unique case (state)
        ee_pkg::EE_IDLE: begin
        end
        ee_pkg::EE_RX: begin
          if (sclRise) begin
            shiftIn <= {shiftIn[6:0], sdaS};
            bitCnt <= bitCnt + 4'h1;
          end
          if (rxDone) begin
            if (kind == ee_pkg::EE_DEVB) begin
              readMode <= shiftIn[0];
            end
            if (ackNow) begin
              sdaOe <= 1'h1;
              state <= ee_pkg::EE_ACK;
            end else begin
              state <= ee_pkg::EE_IDLE;
            end
          end
        end
        ee_pkg::EE_ACK: begin
          if (sclFall) begin
            sdaOe <= 1'h0;
            bitCnt <= 4'h0;
            state <= ee_pkg::EE_RX;
            kind <= nextKind(kind);
          end
        end
        ee_pkg::EE_TX: begin
          if (sclFall) begin
            if (bitCnt == `EE_BIT_LAST) begin
              sdaOe <= 1'h0;
              state <= ee_pkg::EE_TXACK;
            end else begin
              sdaOe <= !txShift[7];
              txShift <= {txShift[6:0], 1'h0};
              bitCnt <= bitCnt + 4'h1;
            end
          end
        end
        ee_pkg::EE_TXACK: begin
          if (sclRise) begin
            ackSeen <= !sdaS;
          end
          if (sclFall && !ackSeen) begin
            state <= ee_pkg::EE_IDLE;
          end
        end
        default: state <= ee_pkg::EE_IDLE;
      endcase
      // Loading a byte overrides the case above
      if (txLoad) begin
        state <= ee_pkg::EE_TX;
        sdaOe <= !memByte[7];
        txShift <= {memByte[6:0], 1'h0};
        bitCnt <= 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Address counter, protect latch and page buffer
  // ----------------------------------------------------------------
  always_ff @(posedge linkClk) begin
    if (!linkRst_n) begin
      addrCnt <= '0;
      wpLatched <= 1'h0;
      dataSeen <= 1'h0;
      pageValid <= '0;
    end else begin
      if (stopCond) begin
        dataSeen <= 1'h0;
      end
      if (rxDone && ackNow && (kind == ee_pkg::EE_DEVB)) begin
        dataSeen <= 1'h0;
        pageValid <= '0;
        wpLatched <= 1'h0;
      end
      if (rxDone && (kind == ee_pkg::EE_ADRH)) begin
        addrCnt[ADDR_BITS-1:8] <= shiftIn[ADDR_BITS-9:0];
      end
      if (rxDone && (kind == ee_pkg::EE_ADRL)) begin
        addrCnt[7:0] <= shiftIn;
      end
      // Last falling edge ahead of the first data byte
      if ((state == ee_pkg::EE_ACK) && sclFall && (kind == ee_pkg::EE_ADRL)) begin
        wpLatched <= wpSync[1];
      end
      if (rxDone && (kind == ee_pkg::EE_DATA) && !wpLatched) begin
        pageBuf[addrCnt[PAGE_BITS-1:0]] <= shiftIn;
        pageValid[addrCnt[PAGE_BITS-1:0]] <= 1'h1;
        dataSeen <= 1'h1;
        addrCnt[PAGE_BITS-1:0] <= addrCnt[PAGE_BITS-1:0] + PAGE_BITS'(1);
      end
      if (txLoad) begin
        addrCnt <= addrCnt + ADDR_BITS'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Internal write cycle
  // ----------------------------------------------------------------
  always_ff @(posedge linkClk) begin
    if (!linkRst_n) begin
      busy <= 1'h0;
      busyCnt <= 32'h0000_0000;
      progIdx <= '0;
      progPage <= '0;
    end else if (!busy) begin
      // Nothing buffered means nothing to program
      if (stopCond && dataSeen && !readMode) begin
        busy <= 1'h1;
        busyCnt <= 32'(WRITE_CYCLES - 1);
        progIdx <= '0;
        progPage <= addrCnt[ADDR_BITS-1:PAGE_BITS];
      end
    end else begin
      if (!progIdx[PAGE_BITS]) begin
        progIdx <= progIdx + (PAGE_BITS + 1)'(1);
      end
      if (busyCnt == 32'h0000_0000) begin
        busy <= 1'h0;
      end else begin
        busyCnt <= busyCnt - 32'h0000_0001;
      end
    end
  end

  // One buffered byte per cycle; needs WRITE_CYCLES of at least a page
  always_ff @(posedge linkClk) begin
    if (busy && !progIdx[PAGE_BITS] && pageValid[progIdx[PAGE_BITS-1:0]]) begin
      mem[{progPage, progIdx[PAGE_BITS-1:0]}] <= pageBuf[progIdx[PAGE_BITS-1:0]];
    end
  end

  // ----------------------------------------------------------------
  // Open-drain data pin
  // ----------------------------------------------------------------
  always_ff @(posedge linkClk) begin
    sdaOutReg <= 1'h0;
  end

  assign bus.sdaSlaveOe = sdaOe;
  assign bus.sdaSlaveOut = sdaOutReg;

endmodule : ee_eeprom_slave

`default_nettype wire

// *** hw/ee_bus_master.sv ***
// Master end: byte-level two-wire bus controller with clock divider
`timescale 1ns/1ps
`default_nettype none
`include "ee_cfg.svh"

module ee_bus_master #(
  parameter int QUARTER = (`EE_SCL_PERIOD_PS / 4 + `EE_CORE_PERIOD_PS - 1) / `EE_CORE_PERIOD_PS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Bus
  ee_link_if.master bus,
  // Command
  input wire logic cmdValid,
  input wire ee_pkg::ee_op_type cmdOp,
  input wire logic [7:0] cmdData,
  input wire logic cmdAck,
  output logic cmdReady,
  // Response
  output logic rspValid,
  output logic [7:0] rspData,
  output logic rspAck
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ee_pkg::ee_master_state_type state;
  logic [15:0] qCnt;
  logic [1:0] phase;
  logic [3:0] bitCnt;
  logic [8:0] txShift;
  logic [8:0] rxShift;
  logic [1:0] sclSync;
  logic [1:0] sdaSync;
  logic sclOe;
  logic sdaOe;
  logic lineOut;
  logic tick;

  assign tick = (qCnt == 16'(QUARTER - 1));

  // ----------------------------------------------------------------
  // Line synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    sclSync <= {sclSync[0], bus.scl};
    sdaSync <= {sdaSync[0], bus.sda};
  end

  // ----------------------------------------------------------------
  // Quarter-bit divider
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n || (state == ee_pkg::EE_M_IDLE) || tick) begin
      qCnt <= 16'h0000;
    end else begin
      qCnt <= qCnt + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Condition and bit sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= ee_pkg::EE_M_IDLE;
      phase <= 2'h0;
      bitCnt <= 4'h0;
      txShift <= 9'h1FF;
      rxShift <= 9'h000;
      sclOe <= 1'h0;
      sdaOe <= 1'h0;
      cmdReady <= 1'h1;
      rspValid <= 1'h0;
      rspData <= 8'h00;
      rspAck <= 1'h0;
    end else begin
      rspValid <= 1'h0;
      if (state == ee_pkg::EE_M_IDLE) begin
        if (cmdValid && cmdReady) begin
          cmdReady <= 1'h0;
          phase <= 2'h0;
          bitCnt <= 4'h0;
          unique case (cmdOp)
            ee_pkg::EE_OP_START: state <= ee_pkg::EE_M_START;
            ee_pkg::EE_OP_STOP: state <= ee_pkg::EE_M_STOP;
            ee_pkg::EE_OP_WRITE: begin
              state <= ee_pkg::EE_M_BIT;
              txShift <= {cmdData, 1'h1};
            end
            ee_pkg::EE_OP_READ: begin
              state <= ee_pkg::EE_M_BIT;
              txShift <= {8'hFF, !cmdAck};
            end
          endcase
        end
      end else if (tick) begin
        phase <= phase + 2'h1;
        unique case (state)
          ee_pkg::EE_M_START: begin
            unique case (phase)
              2'h0: sdaOe <= 1'h0;
              2'h1: sclOe <= 1'h0;
              2'h2: begin
                // Wait here until the bus is seen free
                if (sclSync[1] && sdaSync[1]) begin
                  sdaOe <= 1'h1;
                end else begin
                  phase <= phase;
                end
              end
              2'h3: sclOe <= 1'h1;
            endcase
          end
          ee_pkg::EE_M_STOP: begin
            unique case (phase)
              2'h0: sdaOe <= 1'h1;
              2'h1: sclOe <= 1'h0;
              2'h2: sdaOe <= 1'h0;
              2'h3: begin
              end
            endcase
          end
          ee_pkg::EE_M_BIT: begin
            unique case (phase)
              2'h0: sdaOe <= !txShift[8];
              2'h1: sclOe <= 1'h0;
              2'h2: rxShift <= {rxShift[7:0], sdaSync[1]};
              2'h3: begin
                sclOe <= 1'h1;
                txShift <= {txShift[7:0], 1'h1};
                bitCnt <= bitCnt + 4'h1;
              end
            endcase
          end
          default: state <= ee_pkg::EE_M_IDLE;
        endcase
        if ((phase == 2'h3) && ((state != ee_pkg::EE_M_BIT) || (bitCnt == `EE_BIT_LAST))) begin
          state <= ee_pkg::EE_M_IDLE;
          cmdReady <= 1'h1;
          rspValid <= 1'h1;
          rspData <= rxShift[8:1];
          rspAck <= !rxShift[0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Open-drain pins
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    lineOut <= 1'h0;
  end

  assign bus.sclOe = sclOe;
  assign bus.sclOut = lineOut;
  assign bus.sdaMasterOe = sdaOe;
  assign bus.sdaMasterOut = lineOut;

endmodule : ee_bus_master

`default_nettype wire

// *** bench/ee_link_asserts.sv ***
// Protocol checks on the two-wire memory link
`timescale 1ns/1ps
`default_nettype none

module ee_link_asserts (
  // Clocks and reset
  input wire logic core_clk,
  input wire logic linkClk,
  input wire logic rst_n,
  // Link lines
  input wire logic sclOe,
  input wire logic sclOut,
  input wire logic sdaMasterOe,
  input wire logic sdaMasterOut,
  input wire logic sdaSlaveOe,
  input wire logic sdaSlaveOut,
  input wire logic scl,
  input wire logic sda
);
  logic seenStart;
  logic hdrPhase;
  logic [3:0] bitCnt;
  logic [7:0] hdrByte;

  // ----
  // Header tracker
  // ----
  always_ff @(posedge linkClk) begin
    if (!rst_n) begin
      seenStart <= 1'b0;
      hdrPhase <= 1'b0;
      bitCnt <= 4'h0;
      hdrByte <= 8'h00;
    end else if ($fell(sda) && scl) begin
      seenStart <= 1'b1;
      hdrPhase <= 1'b1;
      bitCnt <= 4'h0;
    end else if ($rose(scl) && hdrPhase) begin
      bitCnt <= bitCnt + 4'h1;
      // Ninth bit is the ack, not part of the header
      if (bitCnt < 4'h8) begin
        hdrByte <= {hdrByte[6:0], sda};
      end else begin
        hdrPhase <= 1'b0;
      end
    end
  end

  sequence startSeq;
    $fell(sda) && scl;
  endsequence

  sequence stopSeq;
    $rose(sda) && scl;
  endsequence

  // ----
  // Master end
  // ----
  mst_scl_od_a: assert property (@(posedge core_clk) disable iff (!rst_n) sclOe |-> !sclOut)
    else $error("master clock driven high");
  mst_sda_od_a: assert property (@(posedge core_clk) disable iff (!rst_n) sdaMasterOe |-> !sdaMasterOut)
    else $error("master data driven high");
  scl_high_a: assert property (@(posedge core_clk) disable iff (!rst_n) $rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  start_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n) startSeq |-> scl [*8])
    else $error("start not held with clock high");
  stop_release_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    stopSeq |-> !sclOe && !sdaMasterOe && !sdaSlaveOe)
    else $error("lines not released at stop");
  mst_stable_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $changed(sdaMasterOe) && scl |-> $changed(sda))
    else $error("master data moved during clock high");

  // ----
  // Memory end
  // ----
  slv_od_a: assert property (@(posedge linkClk) disable iff (!rst_n) sdaSlaveOe |-> !sdaSlaveOut)
    else $error("slave data driven high");
  slv_edge_a: assert property (@(posedge linkClk) disable iff (!rst_n) $changed(sdaSlaveOe) |-> !scl)
    else $error("slave data moved during clock high");
  no_start_a: assert property (@(posedge linkClk) disable iff (!rst_n) !seenStart |-> !sdaSlaveOe)
    else $error("slave drove before any start");
  hdr_quiet_a: assert property (@(posedge linkClk) disable iff (!rst_n)
    hdrPhase && bitCnt < 4'h8 |-> !sdaSlaveOe)
    else $error("slave drove during header bits");
  hdr_type_a: assert property (@(posedge linkClk) disable iff (!rst_n)
    $rose(scl) && hdrPhase && bitCnt == 4'h8 && hdrByte[7:4] != 4'ha |-> !sdaSlaveOe)
    else $error("foreign header acknowledged");
endmodule : ee_link_asserts

`default_nettype wire

// *** bench/tb.sv ***
// Self-checking bench joining master and memory ends
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic core_clk, linkClk, rst_n, cmdValid, cmdAck, cmdReady, rspValid, rspAck, busy, writeProtect, ak;
  logic [2:0] strap;
  logic [7:0] cmdData, rspData, rd;
  ee_pkg::ee_op_type cmdOp;
  int badCount, checkCount;

  ee_link_if link();
  ee_bus_master #(.QUARTER(8)) ee_bus_master_i (.core_clk(core_clk), .rst_n(rst_n), .bus(link),
    .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdData(cmdData), .cmdAck(cmdAck), .cmdReady(cmdReady),
    .rspValid(rspValid), .rspData(rspData), .rspAck(rspAck));
  // Long enough that the first poll lands inside the write cycle
  ee_eeprom_slave #(.WRITE_CYCLES(400)) ee_eeprom_slave_i (.linkClk(linkClk), .rst_n(rst_n), .bus(link),
    .device_select_strap0(strap[0]), .device_select_strap1(strap[1]), .device_select_strap2(strap[2]),
    .writeProtect(writeProtect), .busy(busy));
  ee_link_asserts ee_link_asserts_i (.core_clk(core_clk), .linkClk(linkClk), .rst_n(rst_n),
    .sclOe(link.sclOe), .sclOut(link.sclOut), .sdaMasterOe(link.sdaMasterOe), .sdaMasterOut(link.sdaMasterOut),
    .sdaSlaveOe(link.sdaSlaveOe), .sdaSlaveOut(link.sdaSlaveOut), .scl(link.scl), .sda(link.sda));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    linkClk = 1'b0;
    #3.1;
    forever #7.5 linkClk = ~linkClk;
  end

  task automatic closeOut();
    $display("checks %0d errors %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : closeOut

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checkCount++;
    if (got !== exp) begin
      badCount++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cmd(input ee_pkg::ee_op_type op, input logic [7:0] d, input logic a);
    int n;
    cmdOp = op;
    cmdData = d;
    cmdAck = a;
    cmdValid = 1'b1;
    @(negedge core_clk);
    cmdValid = 1'b0;
    chk("ready", 8'h00, {7'h00, cmdReady});
    for (n = 0; n < 1000 && rspValid !== 1'b1; n++) @(negedge core_clk);
    if (n == 1000) begin
      badCount++;
      $display("ERROR response expected 1 seen 0");
      closeOut();
    end
    rd = rspData;
    ak = rspAck;
    @(negedge core_clk);
  endtask : cmd

  task automatic st();
    cmd(ee_pkg::EE_OP_START, 8'h00, 1'b0);
  endtask : st

  task automatic sp();
    cmd(ee_pkg::EE_OP_STOP, 8'h00, 1'b0);
  endtask : sp

  task automatic wb(input logic [7:0] d, input logic e);
    cmd(ee_pkg::EE_OP_WRITE, d, 1'b0);
    chk("ack", {7'h00, e}, {7'h00, ak});
  endtask : wb

  task automatic rb(input logic [7:0] e, input logic more);
    cmd(ee_pkg::EE_OP_READ, 8'h00, more);
    chk("read", e, rd);
  endtask : rb

  task automatic setAddr(input logic [15:0] a);
    st();
    wb({4'ha, strap, 1'b0}, 1'b1);
    wb(a[15:8], 1'b1);
    wb(a[7:0], 1'b1);
  endtask : setAddr

  task automatic rdGo();
    st();
    wb({4'ha, strap, 1'b1}, 1'b1);
  endtask : rdGo

  task automatic chkBusy(input logic e);
    // Settle time covers the slave's stop detection
    repeat (16) @(negedge core_clk);
    chk("busy", {7'h00, e}, {7'h00, busy});
  endtask : chkBusy

  task automatic pollDone();
    int n;
    logic got;
    got = 1'b0;
    for (n = 0; n < 30 && !got; n++) begin
      st();
      cmd(ee_pkg::EE_OP_WRITE, {4'ha, strap, 1'b0}, 1'b0);
      got = ak;
      sp();
    end
    chk("nacked polls", 8'h01, {7'h00, n > 1});
    chk("poll ack", 8'h01, {7'h00, got});
  endtask : pollDone

  // ----
  // Scenarios
  // ----
  task automatic sBlank();
    rdGo();
    rb(8'hff, 1'b0);
    sp();
    chkBusy(1'b0);
  endtask : sBlank

  task automatic sAddress();
    logic [7:0] bad [3];
    bad = '{{4'ha, 3'h2, 1'b0}, {4'hb, 3'h3, 1'b0}, {4'h2, 3'h3, 1'b1}};
    foreach (bad[i]) begin
      st();
      wb(bad[i], 1'b0);
      sp();
    end
    strap = 3'h5;
    repeat (8) @(negedge core_clk);
    st();
    wb(8'hab, 1'b1);
    sp();
    chkBusy(1'b0);
    strap = 3'h3;
    repeat (8) @(negedge core_clk);
  endtask : sAddress

  task automatic sPage();
    setAddr(16'h813e);
    wb(8'h11, 1'b1);
    wb(8'h22, 1'b1);
    wb(8'h33, 1'b1);
    sp();
    chkBusy(1'b1);
    pollDone();
    setAddr(16'h013e);
    rdGo();
    rb(8'h11, 1'b1);
    rb(8'h22, 1'b1);
    rb(8'hff, 1'b0);
    sp();
    setAddr(16'h0100);
    rdGo();
    rb(8'h33, 1'b0);
    sp();
  endtask : sPage

  task automatic sWrap();
    setAddr(16'h0000);
    wb(8'h5a, 1'b1);
    wb(8'hc3, 1'b1);
    sp();
    pollDone();
    setAddr(16'h7fff);
    rdGo();
    rb(8'hff, 1'b1);
    rb(8'h5a, 1'b0);
    sp();
    rdGo();
    rb(8'hc3, 1'b0);
    sp();
  endtask : sWrap

  task automatic sProtect();
    writeProtect = 1'b1;
    setAddr(16'h0000);
    wb(8'h11, 1'b0);
    sp();
    chkBusy(1'b0);
    writeProtect = 1'b0;
    setAddr(16'h0000);
    sp();
    chkBusy(1'b0);
    rdGo();
    rb(8'h5a, 1'b1);
    rb(8'hc3, 1'b0);
    sp();
  endtask : sProtect

  task automatic sReset();
    rst_n = 1'b0;
    repeat (20) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (8) @(negedge core_clk);
    rdGo();
    rb(8'h5a, 1'b0);
    sp();
  endtask : sReset

  initial begin
    rst_n = 1'b0;
    cmdValid = 1'b0;
    cmdOp = ee_pkg::EE_OP_START;
    cmdData = 8'h00;
    cmdAck = 1'b0;
    strap = 3'h3;
    writeProtect = 1'b0;
    badCount = 0;
    checkCount = 0;
    repeat (20) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (8) @(negedge core_clk);
    sBlank();
    sAddress();
    sPage();
    sWrap();
    sProtect();
    sReset();
    closeOut();
  end
endmodule : tb

`default_nettype wire
